//--- hw/alpi_panel.sv
// Function
// - non-latching alarm clears with its condition
// - default non-latching; output de-energised in alarm
// - auto-latch holds; early acknowledge remembered
// - manual-latch needs condition gone, then acknowledge
// - alarm flashes lamp and drives outputs
// - acknowledged present alarm lights lamp steadily
// - output lamps follow output states
// - alternate setpoint lamp while alternate used
// - host setpoint lamp; flashes on comms traffic
// - timer lamp steady running, flashing hold
// - manual lamp follows manual mode
// - setpoint committed on release, display flashes
// - select auto-repeats; page returns main view
// - saved mode cleared by reset; power-up always goes to passcode entry
// - page at power-up plus passcode re-enters config
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "alpi_consts.svh"

module alpi_panel
  import alpi_pkg::*;
#(
  parameter int NALARM = 4,
  parameter int NOUT = 4,
  parameter int FLASH_CYC = `ALPI_FLASH_CYC,
  parameter int REPEAT_CYC = `ALPI_REPEAT_CYC,
  parameter int CONFIRM_CYC = `ALPI_CONFIRM_CYC
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NALARM-1:0] alarm_cond,
  input wire logic [NOUT-1:0] out_demand,
  input wire logic [NOUT-1:0] out_alarm_sel,
  input wire logic ack_input,
  input wire logic comms_active,
  input wire alpi_btn_s btn,
  output alpi_lamps_s lamps,
  output logic [NOUT-1:0] out_drive,
  output logic [NALARM-1:0] alarm_active,
  output logic [15:0] setpoint,
  output logic param_step,
  output logic qcfg_mode,
  output logic irq
);

  initial
  begin
    if (NALARM < 1 || NALARM > 4 || NOUT != 4)
      $error("alpi_panel: unsupported NALARM/NOUT");
    if (FLASH_CYC < 2 || REPEAT_CYC < 1 || CONFIRM_CYC < 1)
      $error("alpi_panel: bad timing counts");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    alpi_phase_e phase;
    alpi_view_e view;
    logic [NALARM-1:0] act;
    logic [NALARM-1:0] acked;
    logic [2*NALARM-1:0] latch_mode;
    logic [7:0] ctrl;
    logic [7:0] saved_mode;
    logic [7:0] passcode;
    logic [7:0] code_entry;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [15:0] setpt;
    logic [15:0] pending_sp;
    logic sp_dirty;
    alpi_btn_s btn_q;
    logic ack_in_q;
    logic [31:0] flash_cnt;
    logic flash;
    logic [31:0] rep_cnt;
    logic [31:0] conf_cnt;
    logic step;
    logic [31:0] rdata;
  } alpi_state_s;

  alpi_state_s st_r;
  alpi_state_s st_nxt;

  logic apb_wr;
  logic apb_rd;
  logic rd_setup;
  logic ack_pulse;
  logic [NALARM-1:0] ack_ok;
  logic any_flash;
  logic any_alarm;
  logic [NOUT-1:0] trip_out;
  logic [3:0] ev;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  // read data is taken in setup so it stands through the access cycle
  assign rd_setup = psel && !penable && !pwrite;

  // acknowledge: rising edge of panel button or digital input
  assign ack_pulse = (btn.ack && !st_r.btn_q.ack) ||
                     (ack_input && !st_r.ack_in_q);

  // ---------------------------------------------------------------
  // per-alarm latching
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NALARM; gi++)
    begin : g_alarm
      always_comb
      begin
        unique case (st_r.latch_mode[2*gi +: 2])
          ALPI_AUTOLATCH: ack_ok[gi] = ack_pulse;
          ALPI_MANLATCH: ack_ok[gi] = ack_pulse &&
                                      !alarm_cond[gi];
          default: ack_ok[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  assign any_alarm = |st_r.act;
  assign any_flash = |(st_r.act & ~st_r.acked);

  // alarm outputs de-energise while alarm active
  always_comb
  begin
    trip_out = '0;
    for (int i = 0; i < NOUT; i++)
      trip_out[i] = any_alarm;
  end

  always_comb
  begin
    for (int i = 0; i < NOUT; i++)
      out_drive[i] = out_alarm_sel[i] ? !trip_out[i]
                                      : out_demand[i];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.btn_q = btn;
    st_nxt.ack_in_q = ack_input;
    st_nxt.step = 1'b0;
    ev = '0;

    // flash timebase
    if (st_r.flash_cnt >= 32'(FLASH_CYC - 1))
    begin
      st_nxt.flash_cnt = '0;
      st_nxt.flash = !st_r.flash;
    end
    else
      st_nxt.flash_cnt = st_r.flash_cnt + 32'd1;

    // alarm state per discipline
    for (int i = 0; i < NALARM; i++)
    begin
      unique case (st_r.latch_mode[2*i +: 2])
        ALPI_AUTOLATCH, ALPI_MANLATCH:
        begin
          if (alarm_cond[i] && !st_r.act[i])
          begin
            st_nxt.act[i] = 1'b1;
            st_nxt.acked[i] = 1'b0;
          end
          else if (ack_ok[i] && st_r.act[i])
            st_nxt.acked[i] = 1'b1;
          // auto: remembered ack clears once gone
          if (st_r.act[i] && !alarm_cond[i] &&
              (st_r.acked[i] || ack_ok[i]))
          begin
            st_nxt.act[i] = 1'b0;
            st_nxt.acked[i] = 1'b0;
          end
        end
        default:
        begin
          st_nxt.act[i] = alarm_cond[i];
          if (!alarm_cond[i])
            st_nxt.acked[i] = 1'b0;
          else if (ack_pulse && st_r.act[i])
            st_nxt.acked[i] = 1'b1;
        end
      endcase
      if (alarm_cond[i] && !st_r.act[i])
        ev[`ALPI_IRQ_ALARM] = 1'b1;
    end

    // power-up: page held means quick configuration
    unique case (st_r.phase)
      ALPI_BOOT:
      begin
        if (btn.page || !st_r.ctrl[`ALPI_CTRL_CONFIGURED])
        begin
          st_nxt.phase = ALPI_QCFG_CODE;
          st_nxt.code_entry = '0;
        end
        else
        begin
          st_nxt.phase = ALPI_RUN;
          st_nxt.ctrl = st_r.saved_mode;
        end
      end
      ALPI_QCFG_CODE:
      begin
        if (btn.up && !st_r.btn_q.up)
          st_nxt.code_entry = st_r.code_entry + 8'd1;
        if (btn.down && !st_r.btn_q.down)
          st_nxt.code_entry = st_r.code_entry - 8'd1;
        if (btn.sel && !st_r.btn_q.sel)
        begin
          st_nxt.phase = ALPI_RUN;
          if (st_r.code_entry == st_r.passcode)
          begin
            ev[`ALPI_IRQ_QCFG_OK] = 1'b1;
            st_nxt.ctrl[`ALPI_CTRL_CONFIGURED] = 1'b1;
          end
          else
            ev[`ALPI_IRQ_QCFG_FAIL] = 1'b1;
        end
      end
      default:
      begin
        if (btn.page)
          st_nxt.view = ALPI_VIEW_MAIN;
        // select auto-repeats while held
        if (btn.sel && !st_r.btn_q.sel)
        begin
          st_nxt.view = ALPI_VIEW_PARAM;
          st_nxt.step = 1'b1;
          st_nxt.rep_cnt = '0;
        end
        else if (btn.sel)
        begin
          if (st_r.rep_cnt >= 32'(REPEAT_CYC - 1))
          begin
            st_nxt.rep_cnt = '0;
            st_nxt.step = 1'b1;
          end
          else
            st_nxt.rep_cnt = st_r.rep_cnt + 32'd1;
        end
        // setpoint edit on main view
        if (st_r.view == ALPI_VIEW_MAIN && !btn.page)
        begin
          if (btn.up && !st_r.btn_q.up)
          begin
            st_nxt.pending_sp = st_r.pending_sp + 16'd1;
            st_nxt.sp_dirty = 1'b1;
          end
          if (btn.down && !st_r.btn_q.down)
          begin
            st_nxt.pending_sp = st_r.pending_sp - 16'd1;
            st_nxt.sp_dirty = 1'b1;
          end
          if (st_r.sp_dirty && !btn.up && !btn.down)
          begin
            st_nxt.setpt = st_r.pending_sp;
            st_nxt.sp_dirty = 1'b0;
            st_nxt.conf_cnt = 32'(CONFIRM_CYC);
            ev[`ALPI_IRQ_SP_COMMIT] = 1'b1;
          end
        end
      end
    endcase

    if (st_r.conf_cnt != '0)
      st_nxt.conf_cnt = st_r.conf_cnt - 32'd1;

    // register writes
    if (apb_wr)
    begin
      unique case (paddr)
        `ALPI_OFF_CTRL: st_nxt.ctrl = pwdata[7:0];
        `ALPI_OFF_LATCH: st_nxt.latch_mode = pwdata[2*NALARM-1:0];
        `ALPI_OFF_IRQ_MASK: st_nxt.irq_mask = pwdata[3:0];
        `ALPI_OFF_SETPT:
        begin
          st_nxt.setpt = pwdata[15:0];
          st_nxt.pending_sp = pwdata[15:0];
        end
        `ALPI_OFF_PASS: st_nxt.passcode = pwdata[7:0];
        `ALPI_OFF_MODE: st_nxt.saved_mode = pwdata[7:0];
        default: ;
      endcase
    end

    // read data, status read clears, set wins
    st_nxt.rdata = '0;
    if (rd_setup)
    begin
      unique case (paddr)
        `ALPI_OFF_CTRL: st_nxt.rdata = {24'h0, st_r.ctrl};
        `ALPI_OFF_LATCH: st_nxt.rdata = 32'(st_r.latch_mode);
        `ALPI_OFF_STAT:
          st_nxt.rdata = {20'h0, 4'(st_r.acked), 4'(st_r.act),
                          2'h0, 2'(st_r.phase)};
        `ALPI_OFF_IRQ_STAT: st_nxt.rdata = {28'h0, st_r.irq_stat};
        `ALPI_OFF_IRQ_MASK: st_nxt.rdata = {28'h0, st_r.irq_mask};
        `ALPI_OFF_SETPT: st_nxt.rdata = {16'h0, st_r.setpt};
        `ALPI_OFF_PASS: st_nxt.rdata = {24'h0, st_r.passcode};
        `ALPI_OFF_MODE: st_nxt.rdata = {24'h0, st_r.saved_mode};
        default: st_nxt.rdata = '0;
      endcase
    end
    // only the bits reported to the reader are cleared
    if (apb_rd && paddr == `ALPI_OFF_IRQ_STAT)
      st_nxt.irq_stat = st_r.irq_stat & ~st_r.rdata[3:0];
    st_nxt.irq_stat = st_nxt.irq_stat | ev;

    // running mode is copied to saved_mode; reset clears it
    if (st_r.phase == ALPI_RUN && !(apb_wr && paddr == `ALPI_OFF_MODE))
      st_nxt.saved_mode = st_nxt.ctrl;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.passcode <= `ALPI_PASS_RST;
      st_r.setpt <= `ALPI_SETPT_RST;
      st_r.latch_mode <= '0;
      st_r.phase <= ALPI_BOOT;
    end
    else
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_r.rdata;
  assign irq = |(st_r.irq_stat & st_r.irq_mask);
  assign alarm_active = st_r.act;
  assign setpoint = st_r.setpt;
  assign param_step = st_r.step;
  assign qcfg_mode = (st_r.phase == ALPI_QCFG_CODE);

  always_comb
  begin
    lamps.alarm_lamp = any_flash ? st_r.flash : any_alarm;
    lamps.first_output_lamp = out_drive[0];
    lamps.second_output_lamp = out_drive[1];
    lamps.third_output_lamp = out_drive[2];
    lamps.fourth_output_lamp = out_drive[3];
    lamps.alt_setpoint_lamp = st_r.ctrl[`ALPI_CTRL_ALT_SP];
    lamps.host_setpoint_lamp = comms_active ? st_r.flash
                               : st_r.ctrl[`ALPI_CTRL_HOST_SP];
    lamps.timer_lamp = st_r.ctrl[`ALPI_CTRL_TMR_HOLD] ? st_r.flash
                       : st_r.ctrl[`ALPI_CTRL_TMR_RUN];
    lamps.manual_lamp = st_r.ctrl[`ALPI_CTRL_MANUAL];
    lamps.display_blank = st_r.conf_cnt != '0;
  end

endmodule

//--- pkg/alpi_consts.svh
`ifndef ALPI_CONSTS_SVH
`define ALPI_CONSTS_SVH

// register byte offsets
`define ALPI_OFF_CTRL 12'h000
`define ALPI_OFF_LATCH 12'h004
`define ALPI_OFF_STAT 12'h008
`define ALPI_OFF_IRQ_STAT 12'h00c
`define ALPI_OFF_IRQ_MASK 12'h010
`define ALPI_OFF_SETPT 12'h014
`define ALPI_OFF_PASS 12'h018
`define ALPI_OFF_MODE 12'h01c

// ctrl field positions
`define ALPI_CTRL_CONFIGURED 0
`define ALPI_CTRL_ALT_SP 1
`define ALPI_CTRL_HOST_SP 2
`define ALPI_CTRL_MANUAL 3
`define ALPI_CTRL_TMR_RUN 4
`define ALPI_CTRL_TMR_HOLD 5

// irq bits
`define ALPI_IRQ_ALARM 0
`define ALPI_IRQ_SP_COMMIT 1
`define ALPI_IRQ_QCFG_OK 2
`define ALPI_IRQ_QCFG_FAIL 3

// reset values
`define ALPI_PASS_RST 8'h04
`define ALPI_SETPT_RST 16'h0000
`define ALPI_LATCH_RST 8'h00

// timing in ms, and cycle counts at 50 MHz
`define ALPI_CLK_HZ 50000000
`define ALPI_FLASH_MS 250
`define ALPI_FLASH_CYC ((`ALPI_CLK_HZ / 1000) * `ALPI_FLASH_MS)
`define ALPI_REPEAT_MS 200
`define ALPI_REPEAT_CYC ((`ALPI_CLK_HZ / 1000) * `ALPI_REPEAT_MS)
`define ALPI_CONFIRM_MS 100
`define ALPI_CONFIRM_CYC ((`ALPI_CLK_HZ / 1000) * `ALPI_CONFIRM_MS)

`endif

//--- pkg/alpi_pkg.sv
package alpi_pkg;

  // alarm latching discipline, two bits per alarm
  typedef enum logic [1:0] {
    ALPI_NONLATCH,
    ALPI_AUTOLATCH,
    ALPI_MANLATCH
  } alpi_latch_e;

  typedef enum logic [1:0] {
    ALPI_BOOT,
    ALPI_QCFG_CODE,
    ALPI_RUN
  } alpi_phase_e;

  typedef enum logic [1:0] {
    ALPI_VIEW_MAIN,
    ALPI_VIEW_PARAM
  } alpi_view_e;

  typedef struct packed {
    logic [3:0] raise;
    logic [3:0] acked;
  } alpi_alarm_s;

  typedef struct packed {
    logic up;
    logic down;
    logic sel;
    logic page;
    logic ack;
  } alpi_btn_s;

  typedef struct packed {
    logic alarm_lamp;
    logic first_output_lamp;
    logic second_output_lamp;
    logic third_output_lamp;
    logic fourth_output_lamp;
    logic alt_setpoint_lamp;
    logic host_setpoint_lamp;
    logic timer_lamp;
    logic manual_lamp;
    logic display_blank;
  } alpi_lamps_s;

endpackage

//--- verification/alpi_chk_assertions.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module alpi_chk
  import alpi_pkg::*;
#(
  parameter int NALARM = 4,
  parameter int NOUT = 4,
  parameter int FLASH_CYC = 4
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [NALARM-1:0] alarm_active,
  input wire logic [NOUT-1:0] out_demand,
  input wire logic [NOUT-1:0] out_alarm_sel,
  input wire logic [NOUT-1:0] out_drive,
  input wire alpi_btn_s btn,
  input wire alpi_lamps_s lamps,
  input wire logic [15:0] setpoint,
  input wire logic param_step,
  input wire logic qcfg_mode
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic sp_wr;
  int dark_r;
  assign sp_wr = psel && penable && pwrite && paddr == 12'h014;
  // cycles the lamp has stayed dark during an alarm
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      dark_r <= 0;
    else
      dark_r <= (|alarm_active && !lamps.alarm_lamp) ? dark_r + 1 : 0;
  sequence s_sel_press;
    $rose(btn.sel) && !qcfg_mode;
  endsequence
  sequence s_commit;
    $changed(setpoint) && !$past(sp_wr);
  endsequence
  property p_out_lamps;
    {lamps.first_output_lamp, lamps.second_output_lamp,
      lamps.third_output_lamp, lamps.fourth_output_lamp}
      == {out_drive[0], out_drive[1], out_drive[2], out_drive[3]};
  endproperty
  a_out_lamps: assert property (p_out_lamps)
    else $error("output lamp mismatch");
  property p_alarm_out;
    out_drive == (out_demand & ~out_alarm_sel
      | out_alarm_sel & ~{NOUT{|alarm_active}});
  endproperty
  a_alarm_out: assert property (p_alarm_out)
    else $error("output drive mismatch");
  property p_lamp_lit;
    dark_r <= FLASH_CYC + 2;
  endproperty
  a_lamp_lit: assert property (p_lamp_lit)
    else $error("alarm lamp dark too long");
  property p_sp_release;
    $changed(setpoint) |-> $past(sp_wr)
      || !$past(btn.up) && !$past(btn.down);
  endproperty
  a_sp_release: assert property (p_sp_release)
    else $error("setpoint changed while held");
  property p_sp_flash;
    s_commit |-> ##[0:2] lamps.display_blank;
  endproperty
  a_sp_flash: assert property (p_sp_flash)
    else $error("no confirmation flash");
  property p_step;
    s_sel_press |-> ##[0:2] param_step;
  endproperty
  a_step: assert property (p_step)
    else $error("no step on select");
  property p_qcfg_in;
    $rose(nrst) && btn.page |-> ##[0:2] qcfg_mode;
  endproperty
  a_qcfg_in: assert property (p_qcfg_in)
    else $error("no passcode entry");
  property p_qcfg_out;
    $fell(qcfg_mode) |-> $past(btn.sel) || $past(btn.sel, 2)
      || $past(btn.sel, 3);
  endproperty
  a_qcfg_out: assert property (p_qcfg_out)
    else $error("passcode entry left without select");
endmodule

bind alpi_panel alpi_chk #(
  .NALARM(NALARM),
  .NOUT(NOUT),
  .FLASH_CYC(FLASH_CYC)
) alpi_chk_i (
  .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .alarm_active(alarm_active),
  .out_demand(out_demand), .out_alarm_sel(out_alarm_sel),
  .out_drive(out_drive), .btn(btn), .lamps(lamps),
  .setpoint(setpoint), .param_step(param_step), .qcfg_mode(qcfg_mode)
);

//--- verification/alpi_operator.sv
`timescale 1ns/1ps
// ----
// operator push buttons
// ----
module alpi_operator
  import alpi_pkg::*;
(
  input wire logic core_clk,
  input wire alpi_btn_s want,
  output alpi_btn_s btn
);
  // a finger acts one cycle late; page may be held through power-up
  always @(posedge core_clk)
    btn <= want;
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
// ----
// panel testbench
// ----
module testbench;
  import alpi_pkg::*;
  localparam int FL = 4;
  localparam int RP = 8;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ack_input = 1'b0;
  logic comms_active = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] alarm_cond = 4'h0;
  logic [3:0] out_demand = 4'h0;
  logic [3:0] out_alarm_sel = 4'h0;
  alpi_btn_s want = 5'h00;
  alpi_btn_s btn;
  alpi_lamps_s lamps;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] setpoint;
  logic [15:0] sp;
  logic [3:0] out_drive;
  logic [3:0] alarm_active;
  logic [5:0] c;
  logic pready;
  logic pslverr;
  logic param_step;
  logic qcfg_mode;
  logic irq;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int m;
  int k;
  int idx;

  always #10 core_clk = ~core_clk;

  alpi_panel #(.FLASH_CYC(FL), .REPEAT_CYC(RP), .CONFIRM_CYC(3))
  alpi_panel_inst (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_cond(alarm_cond),
    .out_demand(out_demand), .out_alarm_sel(out_alarm_sel),
    .ack_input(ack_input), .comms_active(comms_active), .btn(btn),
    .lamps(lamps), .out_drive(out_drive), .alarm_active(alarm_active),
    .setpoint(setpoint), .param_step(param_step), .qcfg_mode(qcfg_mode),
    .irq(irq)
  );
  alpi_operator alpi_operator_inst (
    .core_clk(core_clk), .want(want), .btn(btn)
  );

  task conclude;
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      conclude();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one apb transfer; read data is taken at the access edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask

  task press(input alpi_btn_s b, input int n);
    @(posedge core_clk);
    want <= b;
    tick(n);
    want <= 5'h00;
    tick(2);
  endtask

  task boot(input logic pg);
    @(posedge core_clk);
    want <= {3'h0, pg, 1'b0};
    nrst <= 1'b0;
    tick(16);
    nrst <= 1'b1;
    tick(3);
    want <= 5'h00;
  endtask

  task code(input int n);
    repeat (n) press(5'h10, 1);
    press(5'h04, 1);
  endtask

  function logic [3:0] drv(input logic [3:0] dm, input logic [3:0] s);
    return dm & ~s;
  endfunction

  initial
  begin
    void'($urandom(32'h1205));
    boot(1'b1);
    chk(qcfg_mode, 1'b1);
    code(3);
    code(4);
    apb(0, 12'h00c, 32'h0);
    chk(rd[3:2], 2'b10);
    boot(1'b1);
    code(4);
    apb(0, 12'h00c, 32'h0);
    chk({rd[3:2], qcfg_mode}, 3'b010);
    apb(1, 12'h008, 32'hffff_ffff);
    apb(0, 12'h008, 32'h0);
    chk(rd[1:0], 2'h2);
    apb(0, 12'h0fc, 32'h0);
    chk(rd, 32'h0);
    chk(pslverr, 1'b0);
    repeat (6)
    begin
      c = (6'($urandom) & 6'h1f) | 6'h01;
      apb(1, 12'h000, {26'h0, c});
      chk({lamps.timer_lamp, lamps.manual_lamp, lamps.host_setpoint_lamp,
        lamps.alt_setpoint_lamp}, c[4:1]);
      apb(0, 12'h01c, 32'h0);
      chk(rd[5:0], c);
    end
    @(posedge core_clk);
    comms_active <= 1'b1;
    apb(1, 12'h000, 32'h35);
    m = 0;
    k = 0;
    repeat (2 * FL + 2)
    begin
      @(negedge core_clk);
      m += lamps.timer_lamp;
      k += lamps.host_setpoint_lamp;
    end
    chk(m > 0 && m < 2 * FL + 2, 1'b1);
    chk(k > 0 && k < 2 * FL + 2, 1'b1);
    @(posedge core_clk);
    comms_active <= 1'b0;
    for (int md = 0; md < 3; md++)
    begin
      idx = $urandom_range(3, 0);
      apb(1, 12'h004, 32'(md) << (2 * idx));
      apb(1, 12'h010, 32'(md != 2));
      @(posedge core_clk);
      out_alarm_sel <= 4'($urandom);
      out_demand <= 4'($urandom);
      alarm_cond[idx] <= 1'b1;
      tick(3);
      chk(alarm_active, 4'h1 << idx);
      chk(out_drive, drv(out_demand, out_alarm_sel));
      chk(irq, md != 2);
      apb(0, 12'h00c, 32'h0);
      chk({rd[0], irq}, 2'b10);
      press(5'h01, 1);
      chk(alarm_active, 4'h1 << idx);
      m = 0;
      repeat (2 * FL + 2)
      begin
        @(negedge core_clk);
        m += lamps.alarm_lamp;
      end
      chk(m == 2 * FL + 2, md != 2);
      @(posedge core_clk);
      alarm_cond[idx] <= 1'b0;
      tick(3);
      chk(alarm_active, 4'(md == 2) << idx);
      @(posedge core_clk);
      ack_input <= 1'b1;
      tick(2);
      ack_input <= 1'b0;
      tick(3);
      chk(alarm_active, 4'h0);
    end
    sp = 16'($urandom_range(32'h7fff, 32'h0010));
    apb(1, 12'h014, {16'h0, sp});
    @(posedge core_clk);
    want <= 5'h10;
    tick(4);
    want <= 5'h00;
    chk(setpoint, sp);
    tick(4);
    chk(setpoint, sp + 16'h1);
    press(5'h04, 1);
    press(5'h02, 1);
    press(5'h08, 1);
    tick(2);
    chk(setpoint, sp);
    m = 0;
    @(posedge core_clk);
    want <= 5'h04;
    repeat (3 * RP)
    begin
      @(negedge core_clk);
      m += param_step;
    end
    @(posedge core_clk);
    want <= 5'h00;
    chk(m >= 3 && m <= 4, 1'b1);
    conclude();
  end
endmodule
